// ---- bench/test_tsp_port.sv ----
// self-checking bench for the serial to parallel port
`timescale 1ns/10ps
`define CHK(n,e,a) begin samples_checked++; if ((a) !== (e)) begin \
  n_mismatch++; $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module test_tsp_port;
  import tsp_pkg::*;
  logic       clk = 1'b0, rst_n = 1'b0, master_mode_select = 1'b1, msl = 1'b1;
  logic       ch32 = 1'b1, cwr = 1'b0, cs_n = 1'b1, oe_n = 1'b1;
  logic       rw = 1'b1, bc = 1'b0;
  logic [5:0] addr = 6'h00;
  logic [7:0] cdat = 8'h00, data = 8'h00, dout, ctrl;
  logic       soa, sob, doe, busy, aoe, boe_n, bwe_n, coe, cst_n, dsel_n;
  logic [4:0] baddr;
  logic       bclk, fr_n, ser, bout;
  logic [8:0] cyc;
  int         n_mismatch = 0, samples_checked = 0;
  always #5 clk = ~clk;
  tsp_link_model i_link (.o_bclk(bclk), .o_frame_n(fr_n), .o_ser(ser),
    .o_cyc(cyc));
  tsp_port i_dut (.i_clk(clk), .i_reset_n(rst_n), .i_bit_clock_in(bclk),
    .i_frame_n(fr_n), .i_serial_in(ser), .o_serial_out_a(soa),
    .o_serial_out_b(sob), .i_master_mode_select(master_mode_select),
    .i_mode_select_line(msl), .i_ch32(ch32), .i_ctrl_wr(cwr),
    .i_ctrl_data(cdat), .o_ctrl(ctrl), .i_cs_n(cs_n), .i_oe_n(oe_n),
    .i_rw(rw), .i_addr(addr), .i_data(data), .o_data(dout),
    .o_data_oe(doe), .o_busy_out(bout), .o_busy_oe(busy), .o_addr(baddr),
    .o_addr_oe(aoe), .o_oe_n(boe_n), .o_we_n(bwe_n), .o_ctl_oe(coe),
    .o_chan_start_n(cst_n), .o_delayed_sel_n(dsel_n));
  // peripheral answers its address; idle bus shows the inverse
  always @(negedge clk)
    if (bc) data <= boe_n ? ~{3'h5, baddr} : {3'h5, baddr};
  ////////////////////////////////////////////////////////////////////
  task automatic wait_cyc(input logic [8:0] c);
    do @(posedge bclk); while (cyc !== c);
  endtask
  // second clock of each bit, well clear of the output latency
  task automatic chk_ser(input logic [4:0] ch, input logic [7:0] a, b);
    for (int k = 0; k < 8; k++) begin
      wait_cyc({ch, 3'(k), 1'b1});
      `CHK("ser a", a[7-k], soa)
      `CHK("ser b", b[7-k], sob)
    end
  endtask
  // host keeps the cycle open while busy stands, bounded
  task automatic host(input logic r, input logic [5:0] a,
                      input logic [7:0] d, input logic bz);
    @(negedge clk);
    cs_n = 1'b0;
    rw = r;
    oe_n = ~r;
    addr = a;
    data = d;
    repeat (6) @(negedge clk);
    `CHK("busy", bz, busy)
    if (bz) `CHK("busy level", 1'b0, bout)
    for (int n = 0; n < 400 && busy !== 1'b0; n++) @(negedge clk);
    `CHK("busy end", 1'b0, busy)
    repeat (6) @(negedge clk);
    if (r) `CHK("rdata", d, dout)
    if (r) `CHK("data oe", 1'b1, doe)
    cs_n = 1'b1;
    oe_n = 1'b1;
    repeat (6) @(negedge clk);
  endtask
  task automatic t_ctrl;
    @(negedge clk);
    cdat = 8'h5C;
    cwr = 1'b1;
    @(negedge clk);
    cwr = 1'b0;
    repeat (2) @(negedge clk);
    `CHK("ctrl set", 8'h5C, ctrl)
    master_mode_select = 1'b0;
    repeat (8) @(negedge clk);
    `CHK("ctrl clr", 8'h00, ctrl)
    cwr = 1'b1;
    @(negedge clk);
    cwr = 1'b0;
    repeat (2) @(negedge clk);
    `CHK("ctrl idle", 8'h00, ctrl)
    $display("done ctrl");
  endtask
  task automatic t_fast;
    wait_cyc({5'd20, 4'h0});
    host(1'b0, 6'h05, 8'h3C, 1'b0);
    host(1'b0, 6'h25, 8'hFF, 1'b0);
    host(1'b0, 6'h26, 8'h00, 1'b0);
    chk_ser(5'd5, 8'h3C, 8'hFF);
    chk_ser(5'd6, 8'h00, 8'h00);
    // reads aimed away from the live channel, so no busy
    host(1'b1, 6'h0A, 8'h0A ^ 8'hA5, 1'b0);
    host(1'b1, 6'h2B, 8'h0B ^ 8'hA5, 1'b0);
    wait_cyc({5'd12, 4'h0});
    host(1'b1, 6'h0C, 8'h0C ^ 8'hA5, 1'b1);
    wait_cyc({5'd14, 4'h0});
    host(1'b0, 6'h0F, 8'h81, 1'b1);
    wait_cyc(9'h000);
    chk_ser(5'd15, 8'h81, 8'h00);
    chk_ser(5'd25, 8'h00, 8'h00);
    @(negedge clk);
    ch32 = 1'b0;
    wait_cyc(9'h000);
    chk_ser(5'd25, 8'hFF, 8'hFF);
    @(negedge clk);
    ch32 = 1'b1;
    $display("done fast");
  endtask
  task automatic t_bus;
    logic [4:0] n;
    @(negedge clk);
    msl = 1'b0;
    bc = 1'b1;
    cs_n = 1'b0;
    wait_cyc(9'h000);
    wait_cyc(9'h000);
    for (int i = 0; i < 2; i++) begin
      n = i ? 5'd31 : 5'd0;
      wait_cyc({n, 4'h1});
      `CHK("rd addr", n + 5'd1, baddr)
      `CHK("oe", 1'b0, boe_n)
      `CHK("strobe", 1'b0, cst_n)
      `CHK("drv", 1'b1, aoe)
      `CHK("ctl drv", 1'b1, coe)
      wait_cyc({n, 4'h5});
      `CHK("wr addr", n - 5'd1, baddr)
      `CHK("we", 1'b0, bwe_n)
      `CHK("wdata", {3'h0, n - 5'd1} ^ 8'hA5, dout)
      `CHK("wr drv", 1'b1, doe)
      wait_cyc({n, 4'h9});
      `CHK("dsel", 1'b0, dsel_n)
      `CHK("strobe hi", 1'b1, cst_n)
      chk_ser(n + 5'd1, {3'h5, n + 5'd1}, 8'hFF);
    end
    @(negedge clk);
    cs_n = 1'b1;
    repeat (40) @(negedge clk);
    `CHK("drv off", 1'b0, aoe | coe | doe)
    $display("done bus");
  endtask
  task automatic print_verdict;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    repeat (10) @(negedge clk);
    t_ctrl;
    t_fast;
    t_bus;
    print_verdict;
  end
  // watchdog: about eight frames of margin over the expected run
  initial begin
    #900000;
    n_mismatch++;
    print_verdict;
  end
endmodule

// ---- bench/tsp_link_model.sv ----
// link partner: free running bit clock, frame pulse and receive stream
`timescale 1ns/10ps
module tsp_link_model (
  // link pins
  output logic       o_bclk,
  output logic       o_frame_n,
  output logic       o_ser,
  // falling edges counted into the frame
  output logic [8:0] o_cyc
);
  logic [8:0] nxt;
  logic [7:0] pat;
  initial begin
    o_bclk    = 1'b1;
    o_frame_n = 1'b1;
    o_ser     = 1'b1;
    o_cyc     = 9'h1F0;
  end
  // 125 ns period, runs free as the link clock does
  always #62.5 o_bclk = ~o_bclk;
  // pulse straddles the falling edge that opens the frame
  always @(posedge o_bclk) o_frame_n <= (o_cyc != 9'h1FF);
  // byte is channel xor a5, msb first, two clocks a bit
  assign nxt = o_cyc + 9'h001;
  assign pat = {3'h0, nxt[8:4]} ^ 8'hA5;
  always @(negedge o_bclk) begin
    o_cyc <= nxt;
    o_ser <= pat[3'h7 - nxt[3:1]];
  end
endmodule

// ---- verilog/tsp_pkg.sv ----
// constants and carrier types for the serial to parallel port
package tsp_pkg;
  localparam int         TSP_NCH      = 32;
  localparam logic [4:0] TSP_LAST24   = 5'h17;
  localparam logic [4:0] TSP_LAST32   = 5'h1F;
  localparam logic [4:0] TSP_HALF_ACC = 5'h1F;
  localparam logic [1:0] TSP_PH_RX    = 2'h2;
  localparam logic [1:0] TSP_PH_TX    = 2'h0;
  localparam logic [3:0] TSP_SUB_LAT  = 4'h7;
  localparam logic [3:0] TSP_SUB_WR   = 4'h8;
  localparam logic [7:0] TSP_IDLE     = 8'hFF;
  localparam logic [7:0] TSP_CTRL_RST = 8'h00;

  typedef enum logic [1:0] {TSP_MICRO, TSP_FAST, TSP_BUSC} tsp_mode_t;

  // pins from outside the clock domain
  typedef struct packed {
    logic       clk;
    logic       frame_n;
    logic       ser_in;
    logic       master_mode_select;
    logic       msl;
    logic       ch32;
    logic       cs_n;
    logic       oe_n;
    logic       rw;
    logic [5:0] addr;
    logic [7:0] data;
  } tsp_pin_t;

  // whole state of the port
  typedef struct packed {
    tsp_pin_t           s1;
    tsp_pin_t           s2;
    tsp_pin_t           s3;
    tsp_pin_t           f;
    logic               clk_d;
    logic               fr_d;
    logic               armed;
    logic [4:0]         half;
    logic [4:0]         ch;
    logic [7:0]         rxsh;
    logic [7:0]         sh_a;
    logic [7:0]         sh_b;
    logic               soa;
    logic               sob;
    logic [7:0]         ctrl;
    logic               done;
    logic               busy;
    logic [7:0]         dout;
    logic               doe;
    logic [4:0]         addr;
    logic               aoe;
    logic               oe_n;
    logic               we_n;
    logic               coe;
    logic               cst_n;
    logic               dcs_n;
    logic [31:0][7:0]   rx;
    logic [31:0][7:0]   txa;
    logic [31:0][7:0]   txb;
  } tsp_st_t;
endpackage

// ---- verilog/tsp_port.sv ----
// serial tdm stream to parallel port, fast ram and bus controller modes
`timescale 1ns/10ps
module tsp_port (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  // serial link pins
  input  wire logic       i_bit_clock_in,
  input  wire logic       i_frame_n,
  input  wire logic       i_serial_in,
  output logic            o_serial_out_a,
  output logic            o_serial_out_b,
  // mode straps
  input  wire logic       i_master_mode_select,
  input  wire logic       i_mode_select_line,
  input  wire logic       i_ch32,
  // control byte write, same clock domain
  input  wire logic       i_ctrl_wr,
  input  wire logic [7:0] i_ctrl_data,
  output logic [7:0]      o_ctrl,
  // parallel port
  input  wire logic       i_cs_n,
  input  wire logic       i_oe_n,
  input  wire logic       i_rw,
  input  wire logic [5:0] i_addr,
  input  wire logic [7:0] i_data,
  output logic [7:0]      o_data,
  output logic            o_data_oe,
  output logic            o_busy_out,
  output logic            o_busy_oe,
  // bus controller outputs
  output logic [4:0]      o_addr,
  output logic            o_addr_oe,
  output logic            o_oe_n,
  output logic            o_we_n,
  output logic            o_ctl_oe,
  output logic            o_chan_start_n,
  output logic            o_delayed_sel_n
);
  import tsp_pkg::*;

  tsp_st_t   r;
  tsp_st_t   n;
  tsp_pin_t  pins;
  tsp_pin_t  chg;
  tsp_mode_t mode;
  logic      ev;
  logic      sof;
  logic      live;
  logic      rd;
  logic      wr;
  logic      col;
  logic [4:0] nh;
  logic [4:0] nch;
  logic [4:0] last;
  logic [4:0] hch;

  ////////////////////////////////////////////////////////////////////////
  // pin bundle into the synchroniser
  assign pins = '{clk: i_bit_clock_in, frame_n: i_frame_n,
                  ser_in: i_serial_in, master_mode_select: i_master_mode_select,
                  msl: i_mode_select_line, ch32: i_ch32, cs_n: i_cs_n,
                  oe_n: i_oe_n, rw: i_rw, addr: i_addr, data: i_data};

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    n    = r;
    // three stages; a bit moves once stages two and three agree
    // one chain for every pin, filtered bit by bit, so a bus word can move a bit at a time
    n.s1 = pins;
    n.s2 = r.s1;
    n.s3 = r.s2;
    chg  = tsp_pin_t'(r.s2 ^ r.s3);
    n.f  = tsp_pin_t'((~chg & r.s3) | (chg & r.f));
    n.clk_d = r.f.clk;
    n.fr_d  = r.f.frame_n;
    // mode decode from the straps
    if (r.f.master_mode_select) begin
      mode = TSP_MICRO;
    end else if (r.f.msl) begin
      mode = TSP_FAST;
    end else begin
      mode = TSP_BUSC;
    end
    last = r.f.ch32 ? TSP_LAST32 : TSP_LAST24;
    ev   = r.f.clk ^ r.clk_d;
    sof  = r.armed & r.clk_d & ~r.f.clk;
    nh   = sof ? 5'h00 : 5'(r.half + 5'h01);
    nch  = sof ? 5'h00 : ((r.half == TSP_HALF_ACC) ?
                          5'(r.ch + 5'h01) : r.ch);
    live = (5'(r.ch + 5'h01) <= last);
    hch  = r.f.addr[4:0];
    rd   = ~r.f.cs_n & r.f.rw & ~r.f.oe_n;
    wr   = ~r.f.cs_n & ~r.f.rw;
    // read hits the slot on the line, write hits the slot about to load
    col  = (rd & (hch == r.ch)) |
           (wr & (hch == 5'(r.ch + 5'h01)));

    // control byte: cleared while the select pin is held low
    if (!r.f.master_mode_select) begin
      n.ctrl = TSP_CTRL_RST;
    end else if (i_ctrl_wr) begin
      n.ctrl = i_ctrl_data;
    end

    // serial timing, stepped on every bit clock edge
    if (ev) begin
      if (sof) begin
        n.armed = 1'b0;
      end
      n.half = nh;
      n.ch   = nch;
      if (nh[1:0] == TSP_PH_RX) begin
        n.rxsh = {r.rxsh[6:0], r.f.ser_in};
      end
      // converters get the rams only in the last half cycle
      if (nh == TSP_HALF_ACC) begin
        if (r.ch <= last) begin
          n.rx[r.ch] = r.rxsh;
        end
        n.sh_a = live ? r.txa[5'(r.ch + 5'h01)] : TSP_IDLE;
        n.sh_b = (live && mode != TSP_BUSC) ?
                 r.txb[5'(r.ch + 5'h01)] : TSP_IDLE;
      end
      // msb first; outputs never float
      if (nh[1:0] == TSP_PH_TX) begin
        n.soa = r.sh_a[~nh[4:2]];
        n.sob = r.sh_b[~nh[4:2]];
      end
      n.cst_n = nh[4];
      n.dcs_n = ~nh[4];
      // bus controller: first two bits read n+1, next two write n-1
      if (mode == TSP_BUSC) begin
        n.aoe = ~r.f.cs_n;
        n.coe = ~r.f.cs_n;
        if (!nh[3]) begin
          n.addr = 5'(nch + 5'h01);
          n.oe_n = 1'b0;
          n.we_n = 1'b1;
          n.doe  = 1'b0;
          if (nh[3:0] == TSP_SUB_LAT && !r.f.cs_n) begin
            n.txa[5'(nch + 5'h01)] = r.f.data;
          end
        end else begin
          n.addr = 5'(nch - 5'h01);
          n.oe_n = 1'b1;
          n.we_n = 1'b0;
          n.dout = r.rx[5'(nch - 5'h01)];
          n.doe  = ~r.f.cs_n;
        end
      end
    end

    // frame pulse arms; next falling bit clock edge opens the frame
    // placed after the edge step so a fresh pulse wins over the clear
    if (r.fr_d && !r.f.frame_n) begin
      n.armed = 1'b1;
    end

    // fast ram host side; the host waits out busy by holding cs low
    if (mode == TSP_FAST) begin
      n.aoe  = 1'b0;
      n.coe  = 1'b0;
      n.busy = col;
      n.doe  = rd & ~col;
      if (rd && !col) begin
        n.dout = r.rx[hch];
      end
      // one write per cs low period, taken once clear of collision
      // a write held off by busy is taken only if cs stays low until busy clears, lost if cs rises first
      if (wr && !col && !r.done) begin
        n.done = 1'b1;
        if (r.f.addr[5]) begin
          n.txb[hch] = r.f.data;
        end else begin
          n.txa[hch] = r.f.data;
        end
      end
      if (r.f.cs_n) begin
        n.done = 1'b0;
      end
    end else begin
      n.busy = 1'b0;
      n.done = 1'b0;
      if (mode == TSP_MICRO) begin
        n.doe = 1'b0;
        n.aoe = 1'b0;
        n.coe = 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs straight from the state register, except the busy level, which is tied low
  assign o_serial_out_a  = r.soa;
  assign o_serial_out_b  = r.sob;
  assign o_ctrl          = r.ctrl;
  assign o_data          = r.dout;
  assign o_data_oe       = r.doe;
  // busy line is open drain: level fixed low, the enable does the work
  assign o_busy_out      = 1'b0;
  assign o_busy_oe       = r.busy;
  assign o_addr          = r.addr;
  assign o_addr_oe       = r.aoe;
  assign o_oe_n          = r.oe_n;
  assign o_we_n          = r.we_n;
  assign o_ctl_oe        = r.coe;
  assign o_chan_start_n  = r.cst_n;
  assign o_delayed_sel_n = r.dcs_n;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  sequence s_read_phase;
    mode == TSP_BUSC && ev && nh[3:0] == 4'h0;
  endsequence

  sequence s_write_phase;
    mode == TSP_BUSC && ev && nh[3:0] == TSP_SUB_WR;
  endsequence

  a_ctrl_clear: assert property (!r.f.master_mode_select |=> r.ctrl == 8'h00)
    else $error("control byte not cleared by select pin");

  // the clear takes one cycle on entry, so let it settle before watching
  a_ctrl_idle: assert property
    (mode == TSP_FAST ##1 mode == TSP_FAST |=> $stable(r.ctrl))
    else $error("control byte moved in fast ram mode");

  a_rx_window: assert property
    ($changed(r.rx) |-> r.half == TSP_HALF_ACC)
    else $error("receive ram written outside last half");

  a_busy_read: assert property
    (mode == TSP_FAST && rd && hch == r.ch |=> r.busy && !r.doe)
    else $error("read collision did not raise busy");

  a_busy_write: assert property
    (mode == TSP_FAST && wr && hch == 5'(r.ch + 5'h01) && !r.done
     |=> r.busy && $stable(r.txa) && $stable(r.txb))
    else $error("write collision not held off");

  a_read_addr: assert property
    (s_read_phase |=> r.addr == 5'(r.ch + 5'h01) && !r.oe_n && r.we_n)
    else $error("read phase address or strobe wrong");

  a_write_addr: assert property
    (s_write_phase |=> r.addr == 5'(r.ch - 5'h01) && !r.we_n && r.oe_n)
    else $error("write phase address or strobe wrong");

  a_bus_sync: assert property
    (mode == TSP_BUSC && !ev |=> $stable(r.addr) && $stable(r.we_n))
    else $error("bus output moved between clock edges");

  a_drv_cs: assert property
    (mode == TSP_BUSC && ev && r.f.cs_n |=> !r.aoe && !r.doe)
    else $error("drivers enabled with cs high");

  a_strobes: assert property
    (ev && nh == 5'h00 |=> !r.cst_n && r.dcs_n ##0 r.half == 5'h00)
    else $error("channel strobes wrong at channel start");

  a_dsel_half: assert property
    (ev && nh == 5'h10 |=> r.cst_n && !r.dcs_n)
    else $error("delayed select wrong at mid channel");

  a_out_b_ff: assert property
    (ev && nh[1:0] == 2'h0 && r.sh_b == 8'hFF |=> r.sob)
    else $error("ff byte did not hold output b high");

endmodule
